// File: rtl/scsr_defines.vh
// Purpose: constants for the synthesizer control and status register bank
// Assumes: 32-bit serial words, address in bits 30:27, data in 26:0
// Notes: definitions only
`ifndef SCSR_DEFINES_VH
`define SCSR_DEFINES_VH

`define SCSR_DATA_W 27
`define SCSR_ADDR_W 4
`define SCSR_WORD_W 32
`define SCSR_RW_BIT 31
`define SCSR_ADDR_HI 30
`define SCSR_ADDR_LO 27

`define SCSR_ADDR_FASTLOCK 4'h7
`define SCSR_ADDR_REGULATOR 4'h8
`define SCSR_ADDR_TESTINIT 4'h9
`define SCSR_ADDR_STATUS 4'ha
`define SCSR_ADDR_IDENT 4'hb

`define SCSR_FL_HIZ 25
`define SCSR_FL_DRIVE 24
`define SCSR_FL_SPI_OUT_OFF 23
`define SCSR_FL_SRC_HI 22
`define SCSR_FL_SRC_LO 21
`define SCSR_FL_PROTECT_OFF 20
`define SCSR_FL_SLIP_EN 19
`define SCSR_FL_QUICK_ON 18
`define SCSR_FL_PUMP_HI 17
`define SCSR_FL_PUMP_LO 13
`define SCSR_FL_DUR_HI 12
`define SCSR_FL_DUR_LO 0

`define SCSR_RG_PIN_IGNORE 26
`define SCSR_RG_DIG_HI 17
`define SCSR_RG_DIG_LO 16
`define SCSR_RG_HV_HI 1
`define SCSR_RG_HV_LO 0

`define SCSR_SRC_LOCK 2'h0
`define SCSR_SRC_OSC_DIV 2'h1
`define SCSR_SRC_CAL_DIV 2'h2
`define SCSR_SRC_FL_CLK 2'h3

`define SCSR_RESET_VALUE 27'h0000000
`define SCSR_STATUS_RSV_MASK 27'h003ffff

`endif

// File: rtl/scsr_reg_store.v
// Purpose: small register store for the writable control words
// Assumes: one write port, one registered read port
// Notes: entries cleared by synchronous reset
`timescale 1ns/1ps
module scsr_reg_store #(
    parameter DW = 27,
    parameter AW = 4,
    parameter DEPTH = 16
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data_q
);
    reg [DW-1:0] mem_q [0:DEPTH-1];
    integer i;

    // Storage with reset clear
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {DW{1'b0}};
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data_q <= {DW{1'b0}};
        end else begin
            rd_data_q <= mem_q[rd_addr];
        end
    end
endmodule // scsr_reg_store

// File: rtl/scsr_regs.v
// Purpose: control/status register bank of a PLL synthesizer, SPI reached
// Assumes: serial clock and data sampled synchronously to sys_clk
// Notes: 32-bit frames, msb first; read data shifted out on the shared pin
`timescale 1ns/1ps
`include "scsr_defines.vh"

module scsr_regs #(
    parameter [26:0] ID_CODE = 27'h1234567, // Arbitrary identifier value
    parameter PUMP_W = 5,
    parameter DUR_W = 13
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire spi_clk,
    input wire spi_le,
    input wire spi_din,
    input wire lock_in,
    input wire lock_pin_polarity,
    input wire osc_div_in,
    input wire cal_div_in,
    input wire pfd_tick,
    input wire first_out_powerdown_pin,
    input wire second_out_powerdown_pin,
    input wire [4:0] ldo_up_ok_in,
    input wire [4:0] ldo_overcurrent_in,
    input wire [1:0] chosen_oscillator_in,
    input wire [4:0] chosen_subband_in,
    input wire [31:0] reg_zero_in,
    output reg lock_serial_out_pin_o,
    output reg lock_serial_out_pin_oe,
    output wire shared_pin_drive_type,
    output wire cycle_slip_en,
    output wire quick_lock_on,
    output reg loop_filter_switch_q,
    output reg [PUMP_W-1:0] pump_current_q,
    output reg quick_lock_active_q,
    output wire first_out_pd,
    output wire second_out_pd,
    output wire [1:0] digital_ldo_level,
    output wire [1:0] high_volt_ldo_level,
    output wire digital_ldo_protect_off,
    output reg circuits_powered_q,
    output wire [26:0] test_init_word
);
    // Frame receiver states
    localparam FR_IDLE = 3'b001;
    localparam FR_SHIFT = 3'b010;
    localparam FR_READ = 3'b100;

    reg [2:0] state_q;
    reg sclk_q;
    reg [31:0] shift_q;
    reg [5:0] cnt_q;
    reg read_q;
    reg [26:0] out_q;
    reg [26:0] fl_q;
    reg [26:0] rg_q;
    reg [26:0] ti_q;
    reg [DUR_W-1:0] dur_cnt_q;
    reg fl_clk_q;
    reg programmed_q;
    reg [26:0] status_w;
    reg [26:0] rd_word;
    reg lock_level;
    reg src_bit;
    reg pin_level;
    reg drive_data;
    wire sclk_rise;
    wire sclk_fall;
    wire [3:0] frame_addr;
    wire frame_done;
    wire wr_en;
    wire [26:0] store_rd;
    wire [3:0] look_addr;

    assign sclk_rise = spi_clk & ~sclk_q;
    assign sclk_fall = ~spi_clk & sclk_q;
    assign frame_addr = shift_q[`SCSR_ADDR_HI:`SCSR_ADDR_LO];
    // Latch enable rising closes a frame
    assign frame_done = spi_le & (state_q == FR_SHIFT) & (cnt_q == 6'd32);
    assign wr_en = frame_done & ~shift_q[`SCSR_RW_BIT];
    // Store read address includes the bit being shifted in, so the word
    // is ready one cycle later when the read loads its output shifter
    assign look_addr = {shift_q[2:0], spi_din};

    // Store for words of other registers, read back via serial out
    scsr_reg_store #(
        .DW(27),
        .AW(4),
        .DEPTH(16)
    ) u_store (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_en),
        .wr_addr(frame_addr),
        .wr_data(shift_q[26:0]),
        .rd_addr(look_addr),
        .rd_data_q(store_rd)
    );

    // Edge tracking of the serial clock
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi_clk;
        end
    end

    // Serial frame engine: shift in, then shift out on reads
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= FR_IDLE;
            shift_q <= 32'h00000000;
            cnt_q <= 6'h00;
            read_q <= 1'b0;
            out_q <= 27'h0000000;
        end else begin
            case (state_q)
                FR_IDLE: begin
                    read_q <= 1'b0;
                    cnt_q <= 6'h00;
                    if (~spi_le) begin
                        state_q <= FR_SHIFT;
                    end
                end
                FR_SHIFT: begin
                    if (spi_le) begin
                        state_q <= FR_IDLE;
                    end else if (sclk_rise && cnt_q != 6'd32) begin
                        shift_q <= {shift_q[30:0], spi_din};
                        cnt_q <= cnt_q + 6'd1;
                        // Read flag is the first bit; switch to output as the 5th bit shifts in
                        if (cnt_q == 6'd4 && shift_q[3]) begin
                            state_q <= FR_READ;
                            read_q <= 1'b1;
                        end
                    end
                end
                FR_READ: begin
                    if (spi_le) begin
                        state_q <= FR_IDLE;
                        read_q <= 1'b0;
                    end else if (cnt_q == 6'd5) begin
                        out_q <= rd_word;
                        cnt_q <= 6'd6;
                    end else if (sclk_fall) begin
                        out_q <= {out_q[25:0], 1'b0};
                    end
                end
                default: begin
                    state_q <= FR_IDLE;
                end
            endcase
        end
    end

    // Read word select, status and identifier are live
    always @* begin
        status_w = 27'h0000000;
        status_w[17:13] = ldo_up_ok_in;
        status_w[12:8] = ldo_overcurrent_in;
        status_w[7] = lock_in;
        status_w[6:5] = chosen_oscillator_in;
        status_w[4:0] = chosen_subband_in;
        case (shift_q[3:0])
            `SCSR_ADDR_FASTLOCK: rd_word = fl_q;
            `SCSR_ADDR_REGULATOR: rd_word = rg_q;
            `SCSR_ADDR_TESTINIT: rd_word = ti_q;
            `SCSR_ADDR_STATUS: rd_word = status_w & `SCSR_STATUS_RSV_MASK;
            `SCSR_ADDR_IDENT: rd_word = ID_CODE;
            default: rd_word = store_rd;
        endcase
    end

    // Writable registers of this bank; identifier and status ignore writes
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            fl_q <= `SCSR_RESET_VALUE;
            rg_q <= `SCSR_RESET_VALUE;
            ti_q <= `SCSR_RESET_VALUE;
            programmed_q <= 1'b0;
        end else if (wr_en) begin
            case (frame_addr)
                `SCSR_ADDR_FASTLOCK: fl_q <= shift_q[26:0];
                `SCSR_ADDR_REGULATOR: rg_q <= shift_q[26:0];
                `SCSR_ADDR_TESTINIT: ti_q <= shift_q[26:0];
                4'h0: programmed_q <= 1'b1;
                default: programmed_q <= programmed_q;
            endcase
        end
    end

    // Circuits beyond regulators wait for the first write to register 0
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            circuits_powered_q <= 1'b0;
        end else begin
            circuits_powered_q <= programmed_q;
        end
    end

    // Fast-lock slot timing in phase-detector cycles
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            dur_cnt_q <= {DUR_W{1'b0}};
            quick_lock_active_q <= 1'b0;
            fl_clk_q <= 1'b0;
        end else if (wr_en && frame_addr == 4'h0 && fl_q[18]) begin
            dur_cnt_q <= fl_q[`SCSR_FL_DUR_HI:`SCSR_FL_DUR_LO];
            quick_lock_active_q <= 1'b1;
        end else if (quick_lock_active_q && pfd_tick) begin
            fl_clk_q <= ~fl_clk_q;
            if (dur_cnt_q <= {{(DUR_W-1){1'b0}}, 1'b1}) begin
                quick_lock_active_q <= 1'b0;
            end
            dur_cnt_q <= dur_cnt_q - {{(DUR_W-1){1'b0}}, 1'b1};
        end
    end

    // Pump current override and filter switch during the slot
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            pump_current_q <= {PUMP_W{1'b0}};
            loop_filter_switch_q <= 1'b0;
        end else begin
            pump_current_q <= quick_lock_active_q ?
                fl_q[`SCSR_FL_PUMP_HI:`SCSR_FL_PUMP_LO] : reg_zero_in[25:21];
            loop_filter_switch_q <= quick_lock_on & quick_lock_active_q;
        end
    end

    assign shared_pin_drive_type = fl_q[`SCSR_FL_DRIVE];
    assign cycle_slip_en = fl_q[`SCSR_FL_SLIP_EN];
    assign quick_lock_on = fl_q[`SCSR_FL_QUICK_ON];
    assign digital_ldo_protect_off = fl_q[`SCSR_FL_PROTECT_OFF];
    assign digital_ldo_level = rg_q[`SCSR_RG_DIG_HI:`SCSR_RG_DIG_LO];
    assign high_volt_ldo_level = rg_q[`SCSR_RG_HV_HI:`SCSR_RG_HV_LO];
    assign test_init_word = ti_q;
    // Power-down pins: with ignore bit, first pin rules both outputs
    assign first_out_pd = first_out_powerdown_pin | ~circuits_powered_q;
    assign second_out_pd = ~circuits_powered_q | (rg_q[26] ?
        first_out_powerdown_pin :
        (quick_lock_on ? 1'b0 : second_out_powerdown_pin));

    // Shared pin source and level selection
    always @* begin
        lock_level = lock_in ^ lock_pin_polarity;
        case (fl_q[`SCSR_FL_SRC_HI:`SCSR_FL_SRC_LO])
            `SCSR_SRC_LOCK: src_bit = lock_level;
            `SCSR_SRC_OSC_DIV: src_bit = osc_div_in;
            `SCSR_SRC_CAL_DIV: src_bit = cal_div_in;
            `SCSR_SRC_FL_CLK: src_bit = fl_clk_q;
            default: src_bit = lock_level;
        endcase
        drive_data = read_q & ~fl_q[`SCSR_FL_SPI_OUT_OFF];
        pin_level = drive_data ? out_q[26] : src_bit;
    end

    // Pin driver: hi-z, open drain or push-pull
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            lock_serial_out_pin_o <= 1'b0;
            lock_serial_out_pin_oe <= 1'b0;
        end else if (fl_q[`SCSR_FL_HIZ]) begin
            lock_serial_out_pin_o <= 1'b0;
            lock_serial_out_pin_oe <= 1'b0;
        end else if (fl_q[`SCSR_FL_DRIVE]) begin
            lock_serial_out_pin_o <= pin_level;
            lock_serial_out_pin_oe <= 1'b1;
        end else begin
            lock_serial_out_pin_o <= 1'b0;
            lock_serial_out_pin_oe <= ~pin_level;
        end
    end
endmodule // scsr_regs

// File: testbench/scsr_regs_asserts.sv
// Purpose: port checker for the synthesizer register bank
// Assumes: bound into scsr_regs, one clock domain
// Notes: bind statement at the foot
`timescale 1ns/1ps
module scsr_regs_asserts #(
    parameter PUMP_W = 5
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire spi_le,
    input wire pfd_tick,
    input wire first_out_powerdown_pin,
    input wire [31:0] reg_zero_in,
    input wire lock_serial_out_pin_o,
    input wire lock_serial_out_pin_oe,
    input wire shared_pin_drive_type,
    input wire quick_lock_on,
    input wire [PUMP_W-1:0] pump_current_q,
    input wire quick_lock_active_q,
    input wire first_out_pd,
    input wire [1:0] digital_ldo_level,
    input wire [1:0] high_volt_ldo_level,
    input wire circuits_powered_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Pin drive and power-down relations
    a_od_drive_low: assert property (
        lock_serial_out_pin_oe && !shared_pin_drive_type
        && $stable(shared_pin_drive_type) |-> !lock_serial_out_pin_o)
        else $error("open drain pin driven high");
    a_first_pd_pin: assert property (
        circuits_powered_q |-> first_out_pd == first_out_powerdown_pin)
        else $error("first power-down not from its pin");
    // Fast-lock slot
    a_slot_needs_on: assert property (
        $rose(quick_lock_active_q) |-> quick_lock_on)
        else $error("slot started with fast lock off");
    a_idle_pump: assert property (
        !quick_lock_active_q [*3] ##0 $stable(reg_zero_in)
        |-> pump_current_q == reg_zero_in[25:21])
        else $error("idle pump code wrong");
    a_slot_end_tick: assert property (
        $fell(quick_lock_active_q) |-> $past(pfd_tick)
        || $past(pfd_tick, 2) || $past(pfd_tick, 3))
        else $error("slot ended without a tick");
    // Programmed state and frame commits
    a_powered_hold: assert property (
        circuits_powered_q |=> circuits_powered_q)
        else $error("programmed state lost");
    a_powered_commit: assert property (
        $rose(circuits_powered_q) |-> spi_le)
        else $error("powered up inside a frame");
    a_frame_quiet: assert property (
        spi_le [*5] |-> $stable({shared_pin_drive_type, quick_lock_on,
        digital_ldo_level, high_volt_ldo_level}))
        else $error("register output changed between frames");
    // Main scenarios
    c_slot: cover property ($rose(quick_lock_active_q));
    c_powered: cover property ($rose(circuits_powered_q));
    c_push_pull: cover property (lock_serial_out_pin_oe && shared_pin_drive_type);
endmodule // scsr_regs_asserts

bind scsr_regs scsr_regs_asserts #(.PUMP_W(PUMP_W)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_le(spi_le),
    .pfd_tick(pfd_tick), .first_out_powerdown_pin(first_out_powerdown_pin),
    .reg_zero_in(reg_zero_in), .lock_serial_out_pin_o(lock_serial_out_pin_o),
    .lock_serial_out_pin_oe(lock_serial_out_pin_oe),
    .shared_pin_drive_type(shared_pin_drive_type),
    .quick_lock_on(quick_lock_on), .pump_current_q(pump_current_q),
    .quick_lock_active_q(quick_lock_active_q), .first_out_pd(first_out_pd),
    .digital_ldo_level(digital_ldo_level),
    .high_volt_ldo_level(high_volt_ldo_level),
    .circuits_powered_q(circuits_powered_q));

// File: testbench/scsr_host_model.sv
// Purpose: serial host that programs and reads the register bank
// Assumes: signals change on falling sys_clk edges
// Notes: serial clock still outside frames
`timescale 1ns/1ps
module scsr_host_model (
    input wire sys_clk,
    input wire pin_lvl,
    output reg spi_clk = 1'b0,
    output reg spi_le = 1'b1,
    output reg spi_din = 1'b1
);
    // One 32-bit frame msb first; read bits taken late in each high phase
    task xfer(input [31:0] w, output [26:0] r);
        integer i;
        begin
            r = 27'h0;
            @(negedge sys_clk) spi_le = 1'b0;
            for (i = 31; i >= 0; i = i - 1) begin
                spi_din = w[i];
                repeat (4) @(negedge sys_clk);
                spi_clk = 1'b1;
                repeat (3) @(negedge sys_clk);
                if (i <= 27 && i >= 1)
                    r = {r[25:0], pin_lvl};
                @(negedge sys_clk) spi_clk = 1'b0;
            end
            spi_din = ~spi_din;
            repeat (2) @(negedge sys_clk);
            spi_le = 1'b1;
            repeat (4) @(negedge sys_clk);
        end
    endtask
endmodule // scsr_host_model

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the synthesizer register bank
// Assumes: pull-up on the shared pin, power-up wait scaled down
// Notes: inputs change on falling edges
`timescale 1ns/1ps
module tb_top;
    localparam [26:0] ID = 27'h1234567; // Arbitrary identifier value
    reg sys_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg lock_in = 1'b1;
    reg pol = 1'b0;
    reg osc_div = 1'b1;
    reg cal_div = 1'b0;
    reg pfd_tick = 1'b0;
    reg [4:0] up_ok = 5'h16;
    reg [4:0] over_cur = 5'h09;
    reg [4:0] subband = 5'h1b;
    reg [1:0] osc_sel = 2'h2;
    reg [31:0] zero_w = 32'h00600000;
    wire spi_clk, spi_le, spi_din, pin_o, pin_oe, pin_lvl, drv, slip, qon;
    wire lfs, qact, pd1, pd2, prot, powered;
    wire [4:0] pump;
    wire [1:0] dig_lvl, hv_lvl;
    wire [26:0] tinit;
    integer fail_count, tests_run, i, n;
    reg [26:0] r;
    reg pd1_pin = 1'b0;
    reg pd2_pin = 1'b0;
    // Released pin floats to the pull-up level
    assign pin_lvl = pin_oe ? pin_o : 1'b1;
    // 25 MHz clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    scsr_host_model host (.sys_clk(sys_clk), .pin_lvl(pin_lvl),
        .spi_clk(spi_clk), .spi_le(spi_le), .spi_din(spi_din));
    scsr_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
        .spi_le(spi_le), .spi_din(spi_din), .lock_in(lock_in),
        .lock_pin_polarity(pol), .osc_div_in(osc_div), .cal_div_in(cal_div),
        .pfd_tick(pfd_tick), .first_out_powerdown_pin(pd1_pin),
        .second_out_powerdown_pin(pd2_pin), .ldo_up_ok_in(up_ok),
        .ldo_overcurrent_in(over_cur), .chosen_oscillator_in(osc_sel),
        .chosen_subband_in(subband), .reg_zero_in(zero_w),
        .lock_serial_out_pin_o(pin_o), .lock_serial_out_pin_oe(pin_oe),
        .shared_pin_drive_type(drv), .cycle_slip_en(slip),
        .quick_lock_on(qon), .loop_filter_switch_q(lfs),
        .pump_current_q(pump), .quick_lock_active_q(qact),
        .first_out_pd(pd1), .second_out_pd(pd2), .digital_ldo_level(dig_lvl),
        .high_volt_ldo_level(hv_lvl), .digital_ldo_protect_off(prot),
        .circuits_powered_q(powered), .test_init_word(tinit));
    // Compare and count
    task chk(input [26:0] got, input [26:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [26:0] d);
        host.xfer({1'b0, a, d}, r);
    endtask
    task rd(input [3:0] a);
        host.xfer({1'b1, a, 27'h0}, r);
    endtask
    task results;
        begin
            $display("Checks %0d mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        fail_count = 0;
        tests_run = 0;
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(powered, 0);
        chk(pd1, 1);
        chk(pd2, 1);
        repeat (50) @(negedge sys_clk);
        wr(4'h9, 27'h0);
        wr(4'h0, 27'h0);
        chk(powered, 1);
        chk(pd1, 0);
        for (i = 8; i >= 0; i = i - 1)
            wr(i[3:0], 27'h0);
        chk(qact, 0);
        chk(tinit, 0);
        rd(4'hb);
        chk(r, ID);
        rd(4'ha);
        chk(r[26:18], 0);
        chk(r[17:13], up_ok);
        chk(r[12:8], over_cur);
        chk(r[7], lock_in);
        chk(r[6:0], {osc_sel, subband});
        $display("test program done");
        pd1_pin = 1'b1;
        wr(4'h8, {1'b1, 8'h0, 2'h2, 14'h0, 2'h3});
        chk(dig_lvl, 2'h2);
        chk(hv_lvl, 2'h3);
        chk(pd2, 1);
        rd(4'h8);
        chk(r, {1'b1, 8'h0, 2'h2, 14'h0, 2'h3});
        wr(4'h3, 27'h2a5c3f1);
        rd(4'h3);
        chk(r, 27'h2a5c3f1);
        wr(4'h8, 27'h1);
        chk(pd2, 0);
        pd2_pin = 1'b1;
        @(negedge sys_clk);
        chk(pd2, 1);
        $display("test regulator done");
        wr(4'h7, 27'h1180000);
        chk(drv, 1);
        chk(prot, 1);
        chk(slip, 1);
        rd(4'h7);
        chk(r, 27'h1180000);
        // For sources 0 to 2 only the selected source is high, so a wrong pick reads low
        for (i = 0; i < 4; i = i + 1) begin
            osc_div = (i == 1);
            cal_div = (i == 2);
            pol = (i != 0);
            wr(4'h7, {4'h0, i[1:0], 21'h0} | 27'h1000000);
            chk(pin_oe, 1);
            if (i < 3)
                chk(pin_o, 1);
        end
        pol = 1'b1;
        wr(4'h7, 27'h1000000);
        chk(pin_o, 0);
        wr(4'h7, 27'h3000000);
        chk(pin_oe, 0);
        pol = 1'b0;
        lock_in = 1'b0;
        wr(4'h7, 27'h0800000);
        rd(4'hb);
        chk(r, 0);
        lock_in = 1'b1;
        wr(4'hb, 27'h7ffffff);
        wr(4'h7, 27'h0);
        rd(4'hb);
        chk(r, ID);
        $display("test pin done");
        wr(4'h7, {8'h0, 1'b1, 5'h15, 13'd4});
        chk(qon, 1);
        chk(pd2, 0);
        wr(4'h0, 27'h0);
        chk(qact, 1);
        chk(lfs, 1);
        chk(pump, 5'h15);
        n = 0;
        while (qact === 1'b1 && n < 20) begin
            pfd_tick = 1'b1;
            @(negedge sys_clk);
            pfd_tick = 1'b0;
            repeat (2) @(negedge sys_clk);
            n = n + 1;
        end
        chk(n, 4);
        chk(pump, 5'h03);
        chk(lfs, 0);
        $display("test fast lock done");
        results;
    end
endmodule // tb_top
